// ===== logic/osss_pkg.sv
package osss_pkg;
  localparam int GROUP_W = 3;
  localparam int PRIM_W  = 5;
  localparam int TRIM_W  = 4;
  localparam int STARTUP_CYCLES = 1024;
  localparam int STARTUP_W      = 10;
  localparam int QCLK_PER_CYCLE = 4;
  localparam logic [2:0] GRP_SECONDARY = 3'h0;
  localparam logic [2:0] GRP_FAST_RC   = 3'h1;
  localparam logic [2:0] GRP_SLOW_RC   = 3'h2;
  localparam logic [2:0] GRP_PRIMARY   = 3'h3;
  localparam logic [2:0] GRP_PLL       = 3'h7;
  localparam logic [4:0] P_EXTERNAL_CLOCK_WITH_IO_PLL4   = 5'h0d;
  localparam logic [4:0] P_EXTERNAL_CLOCK_WITH_IO_PLL8   = 5'h0e;
  localparam logic [4:0] P_EXTERNAL_CLOCK_WITH_IO_PLL16  = 5'h0f;
  localparam logic [4:0] P_FRC_PLL4    = 5'h01;
  localparam logic [4:0] P_FRC_PLL8    = 5'h0a;
  localparam logic [4:0] P_FRC_PLL16   = 5'h03;
  localparam logic [4:0] P_XT_PLL4     = 5'h05;
  localparam logic [4:0] P_XT_PLL8     = 5'h06;
  localparam logic [4:0] P_XT_PLL16    = 5'h07;
  localparam logic [4:0] P_HS2_PLL4    = 5'h11;
  localparam logic [4:0] P_HS2_PLL8    = 5'h12;
  localparam logic [4:0] P_HS2_PLL16   = 5'h13;
  localparam logic [4:0] P_HS3_PLL4    = 5'h15;
  localparam logic [4:0] P_HS3_PLL8    = 5'h16;
  localparam logic [4:0] P_HS3_PLL16   = 5'h17;
  localparam logic [4:0] P_EXTERNAL_CLOCK_WITH_IO        = 5'h0c;
  localparam logic [4:0] P_XT          = 5'h04;
  localparam logic [4:0] P_HS          = 5'h02;
  localparam logic [4:0] P_EC          = 5'h0b;
  localparam logic [4:0] P_ERC         = 5'h09;
  localparam logic [4:0] P_EXTERNAL_RC_WITH_IO       = 5'h08;
  localparam logic [4:0] P_XTL         = 5'h00;
  localparam logic [1:0] PIN2_OSC  = 2'h0;
  localparam logic [1:0] PIN2_IO   = 2'h1;
  localparam logic [1:0] PIN2_CLOCK_OUT_PIN = 2'h2;
  localparam logic [1:0] PIN2_NONE = 2'h3;
  localparam logic [4:0] PLL_X1  = 5'h01;
  localparam logic [4:0] PLL_X4  = 5'h04;
  localparam logic [4:0] PLL_X8  = 5'h08;
  localparam logic [4:0] PLL_X16 = 5'h10;
  localparam logic [1:0] POST_DIV1_RESET = 2'h0;
  localparam logic [3:0] TRIM_RESET = 4'h0;
endpackage

// ===== logic/osss_startup_counter.sv
`timescale 1ns/1ps
`default_nettype none
module osss_startup_counter
  import osss_pkg::*;
#(
  parameter int COUNT = STARTUP_CYCLES,
  parameter int W     = STARTUP_W
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic restart,
  input  wire logic osc_tick,
  output logic      done
);
  // Done is raised at the wrap, so the count must fill the counter exactly
  if (COUNT != (1 << W)) begin : g_bad_count
    $error("COUNT must equal 2**W");
  end

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_done;

  always_comb begin
    next_count = count;
    next_done  = done;
    if (restart) begin
      next_count = '0;
      next_done  = 1'b0;
    end else if (!done && osc_tick) begin
      next_count = count + 1'b1;
      if (count == W'(COUNT - 1))
        next_done = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end
endmodule
`default_nettype wire

// ===== logic/osss_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
module osss_clock_select
  import osss_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        por_release,
  input  wire logic        bor_release,
  input  wire logic        sleep_wake,
  input  wire logic [2:0]  osc_group_select,
  input  wire logic [4:0]  primary_osc_choice,
  input  wire logic        osc_tick,
  input  wire logic        trim_write,
  input  wire logic [3:0]  trim_wdata,
  input  wire logic        postscale_write,
  input  wire logic [1:0]  postscale_wdata,
  output logic [2:0]       active_group,
  output logic [4:0]       active_choice,
  output logic             config_valid,
  output logic             sys_clock_enable,
  output logic             startup_pending,
  output logic [1:0]       crystal_output_pin_mode,
  output logic             crystal_input_pin_io,
  output logic [4:0]       pll_factor,
  output logic [2:0]       qclk_per_cycle_log2,
  output logic [3:0]       rc_trim_bits,
  output logic [1:0]       postscale_sel
);
  typedef enum logic [1:0] {OSSS_IDLE, OSSS_WAIT, OSSS_RUN} osss_state_e;

  osss_state_e state;
  osss_state_e next_state;
  logic [2:0]  next_group;
  logic [4:0]  next_choice;
  logic        next_valid;
  logic [3:0]  next_trim;
  logic [1:0]  next_post;
  logic [1:0]  next_pin2;
  logic [4:0]  next_pll;
  logic        restart;
  logic        needs_ost;
  logic        sample_cfg;
  logic        ost_done;

  localparam int QCLK_LOG2 = $clog2(QCLK_PER_CYCLE);

  // Port widths are fixed at the pins; refuse a package that disagrees
  if (GROUP_W != 3 || PRIM_W != 5 || TRIM_W != 4) begin : g_bad_width
    $error("field widths do not match the port widths");
  end
  // The done flag sits at the counter's wrap, so the count must fill it
  if (STARTUP_CYCLES != (1 << STARTUP_W)) begin : g_bad_startup
    $error("start-up count must equal two to the counter width");
  end
  // The rate output is a shift, so the phase count must be a power of two
  if (QCLK_PER_CYCLE != (1 << QCLK_LOG2)) begin : g_bad_phase
    $error("phases per instruction must be a power of two");
  end

  function automatic logic is_crystal(input logic [2:0] g,
                                      input logic [4:0] p);
    logic r;
    r = 1'b0;
    if (g == GRP_PRIMARY)
      r = (p == P_XT) || (p == P_HS) || (p == P_XTL);
    else if (g == GRP_PLL)
      r = (p == P_XT_PLL4)  || (p == P_XT_PLL8)  || (p == P_XT_PLL16) ||
          (p == P_HS2_PLL4) || (p == P_HS2_PLL8) || (p == P_HS2_PLL16) ||
          (p == P_HS3_PLL4) || (p == P_HS3_PLL8) || (p == P_HS3_PLL16);
    else if (g == GRP_SECONDARY)
      r = 1'b1;  // Low-power crystal on the secondary oscillator
    return r;
  endfunction

  assign sample_cfg = por_release || bor_release;
  assign needs_ost  = is_crystal(active_group, active_choice);
  // Sleep wake restarts only a stored config; reset releases resample first
  assign restart    = (state != OSSS_IDLE) && sleep_wake && needs_ost;

  osss_startup_counter #(
    .COUNT (STARTUP_CYCLES),
    .W     (STARTUP_W)
  ) u_startup_delay_counter (
    .mclk     (mclk),
    .reset    (reset),
    .restart  (restart || sample_cfg),
    .osc_tick (osc_tick),
    .done     (ost_done)
  );

  // Writable fields; a release resets the postscaler over a same-cycle write
  always_comb begin
    next_trim = rc_trim_bits;
    next_post = postscale_sel;
    if (trim_write)
      next_trim = trim_wdata;
    if (sample_cfg)
      next_post = POST_DIV1_RESET;
    else if (postscale_write)
      next_post = postscale_wdata;
  end

  // Selection and start-up sequencing
  always_comb begin
    next_state  = state;
    next_group  = active_group;
    next_choice = active_choice;
    next_valid  = config_valid;
    if (sample_cfg) begin
      next_group  = osc_group_select;
      next_choice = primary_osc_choice;
      next_valid  = 1'b1;
      next_state  = is_crystal(osc_group_select, primary_osc_choice) ?
                    OSSS_WAIT : OSSS_RUN;
    end else begin
      case (state)
        OSSS_IDLE: next_state = OSSS_IDLE;
        OSSS_WAIT: begin
          // A restart in the last waiting cycle must not let the clock out
          if (ost_done && !restart)
            next_state = OSSS_RUN;
        end
        OSSS_RUN: begin
          if (restart)
            next_state = OSSS_WAIT;
        end
        default:   next_state = OSSS_IDLE;
      endcase
    end
  end

  // Pin function and PLL factor of the stored selection
  always_comb begin
    next_pin2 = PIN2_NONE;
    next_pll  = PLL_X1;
    case (active_group)
      GRP_PLL: begin
        case (active_choice)
          P_EXTERNAL_CLOCK_WITH_IO_PLL4, P_FRC_PLL4, P_XT_PLL4, P_HS2_PLL4, P_HS3_PLL4:
            next_pll = PLL_X4;
          P_EXTERNAL_CLOCK_WITH_IO_PLL8, P_FRC_PLL8, P_XT_PLL8, P_HS2_PLL8, P_HS3_PLL8:
            next_pll = PLL_X8;
          P_EXTERNAL_CLOCK_WITH_IO_PLL16, P_FRC_PLL16, P_XT_PLL16, P_HS2_PLL16, P_HS3_PLL16:
            next_pll = PLL_X16;
          default: next_pll = PLL_X1;
        endcase
        case (active_choice)
          P_EXTERNAL_CLOCK_WITH_IO_PLL4, P_EXTERNAL_CLOCK_WITH_IO_PLL8, P_EXTERNAL_CLOCK_WITH_IO_PLL16,
          P_FRC_PLL4, P_FRC_PLL8, P_FRC_PLL16: next_pin2 = PIN2_IO;
          default: next_pin2 = PIN2_OSC;
        endcase
      end
      GRP_PRIMARY: begin
        case (active_choice)
          P_EXTERNAL_CLOCK_WITH_IO, P_EXTERNAL_RC_WITH_IO: next_pin2 = PIN2_IO;
          P_EC, P_ERC:     next_pin2 = PIN2_CLOCK_OUT_PIN;
          default:         next_pin2 = PIN2_OSC;
        endcase
      end
      GRP_SECONDARY, GRP_FAST_RC, GRP_SLOW_RC: begin
        // Primary pin unused here; the primary choice still governs it
        case (active_choice)
          P_EXTERNAL_CLOCK_WITH_IO, P_EXTERNAL_RC_WITH_IO: next_pin2 = PIN2_IO;
          default:         next_pin2 = PIN2_NONE;
        endcase
      end
      default: next_pin2 = PIN2_NONE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state         <= OSSS_IDLE;
      active_group  <= GRP_FAST_RC;
      active_choice <= 5'h00;
      config_valid  <= 1'b0;
    end else begin
      state         <= next_state;
      active_group  <= next_group;
      active_choice <= next_choice;
      config_valid  <= next_valid;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rc_trim_bits  <= TRIM_RESET;
      postscale_sel <= POST_DIV1_RESET;
    end else begin
      rc_trim_bits  <= next_trim;
      postscale_sel <= next_post;
    end
  end

  // Pin and factor trail the selection by one cycle; they decode stored bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      crystal_output_pin_mode <= PIN2_NONE;
      pll_factor              <= PLL_X1;
    end else begin
      crystal_output_pin_mode <= next_pin2;
      pll_factor              <= next_pll;
    end
  end

  assign sys_clock_enable     = (state == OSSS_RUN);
  assign startup_pending      = (state == OSSS_WAIT);
  assign crystal_input_pin_io = 1'b0;
  // Rate = osc * pll >> log2; the postscaler adds to the phase shift
  assign qclk_per_cycle_log2  = 3'(QCLK_LOG2 + postscale_sel);
endmodule
`default_nettype wire

// ===== tb/osss_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module osss_osc_model (
  input  wire logic mclk,
  input  wire logic run,
  output logic      osc_tick = 1'b0
);
  int gap = 0;
  // Stands still while run is low; one or two idle cycles between ticks
  always @(posedge mclk) begin
    osc_tick <= run && gap == 0;
    if (!run) gap <= 0;
    else if (gap == 0) gap <= 1 + $urandom % 2;
    else gap <= gap - 1;
  end
endmodule
`default_nettype wire

// ===== tb/osss_clock_select_checker.sv
`timescale 1ns/1ps
`default_nettype none
module osss_clock_select_checker
  import osss_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       por_release,
  input wire logic       bor_release,
  input wire logic       sleep_wake,
  input wire logic [2:0] osc_group_select,
  input wire logic [4:0] primary_osc_choice,
  input wire logic       osc_tick,
  input wire logic       trim_write,
  input wire logic [3:0] trim_wdata,
  input wire logic [2:0] active_group,
  input wire logic [4:0] active_choice,
  input wire logic       sys_clock_enable,
  input wire logic       startup_pending,
  input wire logic [1:0] crystal_output_pin_mode,
  input wire logic       crystal_input_pin_io,
  input wire logic [2:0] qclk_per_cycle_log2,
  input wire logic [3:0] rc_trim_bits,
  input wire logic [1:0] postscale_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire rel = por_release | bor_release;
  // Ticks seen while waiting; cleared by every restart of the wait
  logic [10:0] ticks;
  always_ff @(posedge mclk) begin
    if (reset || rel || sleep_wake || !startup_pending)
      ticks <= 11'h000;
    else if (osc_tick && ticks != 11'h7ff)
      ticks <= ticks + 11'h001;
  end
  a_input_not_io: assert property (
    crystal_input_pin_io == 1'b0) else $error("input pin offered as io");
  a_fields_sampled: assert property (por_release |=>
    active_group == $past(osc_group_select) &&
    active_choice == $past(primary_osc_choice)) else $error("fields lost");
  a_gate_in_wait: assert property (
    startup_pending |-> !sys_clock_enable) else $error("clock not gated");
  a_release_at_count: assert property (
    $rose(sys_clock_enable) && $past(startup_pending) && !$past(rel)
    |-> $past(ticks) == 11'h400) else $error("clock let out early");
  a_lp_delayed: assert property (
    rel && osc_group_select == GRP_SECONDARY |=> startup_pending)
    else $error("no start-up delay");
  a_postscale_one: assert property (
    rel |=> postscale_sel == POST_DIV1_RESET) else $error("postscale kept");
  a_trim_taken: assert property (
    trim_write |=> rc_trim_bits == $past(trim_wdata)) else $error("trim lost");
  a_rate_shift: assert property (
    qclk_per_cycle_log2 == 3'h2 + postscale_sel) else $error("bad rate");
  a_io_pin_mode: assert property (
    rel && osc_group_select == GRP_PRIMARY && primary_osc_choice == P_EXTERNAL_CLOCK_WITH_IO
    |=> ##1 crystal_output_pin_mode == PIN2_IO) else $error("pin not io");
endmodule
bind osss_clock_select osss_clock_select_checker u_chk (.*);
`default_nettype wire

// ===== tb/osss_clock_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module osss_clock_select_bench
  import osss_pkg::*;
;
  logic       mclk = 0, reset = 1, run = 0, osc_tick;
  logic       por_release = 0, bor_release = 0, sleep_wake = 0;
  logic       trim_write = 0, postscale_write = 0;
  logic [2:0] osc_group_select = 3'h1, active_group, qclk_per_cycle_log2;
  logic [4:0] primary_osc_choice = 5'h00, active_choice, pll_factor;
  logic [3:0] trim_wdata = 4'h0, rc_trim_bits;
  logic [1:0] postscale_wdata = 2'h0, postscale_sel, crystal_output_pin_mode;
  logic       config_valid, sys_clock_enable, startup_pending;
  logic       crystal_input_pin_io;
  logic [7:0] v;
  int         mismatches = 0, num_checks = 0;
  localparam logic [7:0] T [25] = '{8'hed, 8'hee, 8'hef, 8'he1, 8'hea,
    8'he3, 8'he5, 8'he6, 8'he7, 8'hf1, 8'hf2, 8'hf3, 8'hf5, 8'hf6, 8'hf7,
    8'h6c, 8'h64, 8'h62, 8'h6b, 8'h69, 8'h68, 8'h60, 8'h00, 8'h20, 8'h40};
  osss_clock_select dut (.*);
  osss_osc_model xtal (.*);
  always #12.5 mclk = ~mclk;
  function automatic logic xt(logic [7:0] f);
    return f[7:5] == GRP_SECONDARY || (f[7:5] == GRP_PLL &&
      (f[4] || f[3:2] == 2'b01)) || (f[7:5] == GRP_PRIMARY &&
      f[4:0] inside {P_XT, P_HS, P_XTL});
  endfunction
  function automatic logic [1:0] pin(logic [7:0] f);
    if (f[7:5] < GRP_PRIMARY) return PIN2_NONE;
    if (xt(f)) return PIN2_OSC;
    return f[4:0] inside {P_EC, P_ERC} ? PIN2_CLOCK_OUT_PIN : PIN2_IO;
  endfunction
  task automatic close_out;
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [3:0] t, logic [1:0] p);
    @(posedge mclk);
    trim_write <= 1;
    trim_wdata <= t;
    postscale_write <= 1;
    postscale_wdata <= p;
    @(posedge mclk);
    trim_write <= 0;
    postscale_write <= 0;
    @(negedge mclk);
    chk("trim", rc_trim_bits, t);
    chk("rate", qclk_per_cycle_log2, 3'h2 + p);
  endtask
  // Oscillator held still so every counted tick lands after the sample
  task automatic rel(logic [7:0] f, int k);
    @(posedge mclk);
    osc_group_select <= f[7:5];
    primary_osc_choice <= f[4:0];
    por_release <= k == 0;
    bor_release <= k == 1;
    sleep_wake <= k == 2;
    run <= 0;
    @(posedge mclk);
    por_release <= 0;
    bor_release <= 0;
    sleep_wake <= 0;
    @(posedge mclk);
    @(negedge mclk);
    chk("group", active_group, f[7:5]);
    chk("choice", active_choice, f[4:0]);
    chk("pll", pll_factor, &f[7:5] ? 5'h2 << f[1:0] : PLL_X1);
    chk("pin", crystal_output_pin_mode, pin(f));
    chk("in_io", crystal_input_pin_io, 0);
    chk("pending", startup_pending, xt(f));
    if (k < 2) chk("post", postscale_sel, POST_DIV1_RESET);
    @(posedge mclk);
    run <= 1;
  endtask
  task automatic settle(logic [7:0] f);
    int n;
    n = 0;
    repeat (3000) begin
      @(negedge mclk);
      if (sys_clock_enable === 1'b1) break;
      n += osc_tick;
    end
    chk("ticks", 16'(n), xt(f) ? 16'(STARTUP_CYCLES) : 16'h0);
    chk("enable", sys_clock_enable, 1);
  endtask
  initial begin
    void'($urandom(4));
    repeat (16) @(posedge mclk);
    reset <= 0;
    @(negedge mclk);
    chk("enable", sys_clock_enable, 0);
    chk("post", postscale_sel, POST_DIV1_RESET);
    chk("trim", rc_trim_bits, TRIM_RESET);
    for (int i = 0; i < 29; i++) begin
      v = i < 25 ? T[i] : T[$urandom % 25];
      wr(4'($urandom), 2'($urandom));
      rel(v, i % 2);
      if (i == 6) begin
        repeat (300) @(posedge mclk);
        rel(v, 1);
      end
      settle(v);
      chk("valid", config_valid, 1);
      if (i % 2) begin
        rel(v, 2);
        settle(v);
      end
    end
    @(posedge mclk);
    reset <= 1;
    @(posedge mclk);
    reset <= 0;
    @(negedge mclk);
    chk("enable", sys_clock_enable, 0);
    chk("valid", config_valid, 0);
    chk("post", postscale_sel, POST_DIV1_RESET);
    chk("trim", rc_trim_bits, TRIM_RESET);
    close_out;
  end
  initial begin
    repeat (95000) @(posedge mclk);
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
